// file: sop_clkgen.sv
// master-mode bit clock and frame clock generator divided from the 1024 x fs clock
`timescale 1ns/1ps
`include "sop_regs.svh"

module sop_clkgen (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire sop_pkg::sop_bdiv_t bdiv_i,
    input  wire sop_pkg::sop_fdiv_t fdiv_i,
    input  wire logic              edge_i,
    input  wire logic              pol_i,
    input  wire logic              fst_i,
    output logic                   bclk_o,
    output logic                   lrclk_o
);

    logic [9:0] cnt_reg;
    logic [9:0] fmask;
    logic [9:0] bdiv_val;
    logic [1:0] bsel;
    logic [9:0] fpos;
    logic       bclk_next;
    logic       lrclk_next;

    // ------------------------------------------------------------------
    // free running phase counter at 1024 x fs
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= 10'h000;
        end else begin
            cnt_reg <= cnt_reg + 10'h001;
        end
    end

    // divider decode; reserved frame code falls back to /256
    always_comb begin
        case (fdiv_i)
            2'b00:   fmask = 10'h3FF;
            2'b01:   fmask = 10'h1FF;
            default: fmask = 10'h0FF;
        endcase
        case (bdiv_i)
            2'b00:   bsel = 2'h3;
            2'b01:   bsel = 2'h2;
            2'b10:   bsel = 2'h1;
            default: bsel = 2'h0;
        endcase
        bdiv_val = 10'h002 << bsel;
        fpos     = cnt_reg & fmask;
        // launch edge lines up with frame start, whichever edge is chosen
        bclk_next = cnt_reg[bsel] ^ edge_i;
        if (fst_i) begin
            lrclk_next = (fpos < bdiv_val);
        end else begin
            lrclk_next = (fpos > (fmask >> 1)) ^ pol_i;
        end
    end

    // ------------------------------------------------------------------
    // registered clock outputs keep the pins glitch free
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bclk_o  <= 1'b0;
            lrclk_o <= 1'b0;
        end else begin
            bclk_o  <= bclk_next;
            lrclk_o <= lrclk_next;
        end
    end

endmodule : sop_clkgen

// file: sop_out_asserts.sv
// checker for the serial output port: role, clock dividers, framing, reads
`timescale 1ns/1ps
`include "sop_regs.svh"

module sop_out_asserts (
    input  wire logic        CLK_I,
    input  wire logic        RESET_I,
    input  wire logic [11:0] REG_ADDR_I,
    input  wire logic [15:0] REG_WDATA_I,
    input  wire logic        REG_WR_I,
    input  wire logic        REG_RD_I,
    input  wire logic [15:0] REG_RDATA_O,
    input  wire logic        BCLK_O,
    input  wire logic        BCLK_OE_O,
    input  wire logic        LRCLK_O,
    input  wire logic [3:0]  SDATA_O
);
    // ------
    // helpers
    // ------
    logic [15:0] ctl_reg;
    logic [11:0] quiet_reg;
    logic [9:0]  bc_cnt_reg;
    logic [9:0]  lr_cnt_reg;
    logic        quiet;
    logic        mst;
    assign quiet = (quiet_reg > 12'h834);
    assign mst   = ctl_reg[11] && quiet;

    // control mirror; the settle count hides divider changes mid-period
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            ctl_reg   <= 16'h0000;
            quiet_reg <= 12'h000;
        end else if (REG_WR_I && REG_ADDR_I == `SOP_CTRL_ADDR) begin
            ctl_reg   <= REG_WDATA_I & `SOP_CTRL_WMASK;
            quiet_reg <= 12'h000;
        end else if (quiet_reg != 12'hFFF) begin
            quiet_reg <= quiet_reg + 12'h001;
        end
    end

    // cycles since each generated clock last moved
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            bc_cnt_reg <= 10'h000;
            lr_cnt_reg <= 10'h000;
        end else begin
            bc_cnt_reg <= $changed(BCLK_O) ? 10'h000 : bc_cnt_reg + 10'h001;
            lr_cnt_reg <= $changed(LRCLK_O) ? 10'h000 : lr_cnt_reg + 10'h001;
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);

    sequence s_ctl_write;
        REG_WR_I && REG_ADDR_I == `SOP_CTRL_ADDR;
    endsequence
    property p_oe_reset;
        $fell(RESET_I) |-> !BCLK_OE_O;
    endproperty
    a_oe_reset: assert property (p_oe_reset) else $error("pin driven after reset");
    property p_role;
        s_ctl_write |=> BCLK_OE_O == $past(REG_WDATA_I[11]);
    endproperty
    a_role: assert property (p_role) else $error("role bit not applied");
    property p_bclk_div;
        $changed(BCLK_O) && mst |-> bc_cnt_reg == (10'h008 >> ctl_reg[10:9]) - 10'h001;
    endproperty
    a_bclk_div: assert property (p_bclk_div) else $error("bit clock period wrong");
    property p_word_half;
        $changed(LRCLK_O) && mst && !ctl_reg[6]
            |-> lr_cnt_reg == (10'h200 >> ctl_reg[8:7]) - 10'h001;
    endproperty
    a_word_half: assert property (p_word_half) else $error("word clock half wrong");
    property p_pulse;
        $fell(LRCLK_O) && mst && ctl_reg[6] |-> lr_cnt_reg == (10'h010 >> ctl_reg[10:9]) - 10'h001;
    endproperty
    a_pulse: assert property (p_pulse) else $error("frame pulse width wrong");
    property p_launch;
        $changed(SDATA_O) && mst |-> $past(BCLK_O) == ctl_reg[12] && $past(BCLK_O, 2) != ctl_reg[12];
    endproperty
    a_launch: assert property (p_launch) else $error("data moved off launch edge");
    property p_rdata;
        REG_RD_I && !REG_WR_I && REG_ADDR_I == `SOP_CTRL_ADDR |=> REG_RDATA_O == ctl_reg;
    endproperty
    a_rdata: assert property (p_rdata) else $error("control read wrong");
    property p_tdm_lines;
        quiet && ctl_reg[5] |-> SDATA_O[3:1] == 3'b000;
    endproperty
    a_tdm_lines: assert property (p_tdm_lines) else $error("stereo lines active in tdm");
endmodule : sop_out_asserts

bind sop_out_port sop_out_asserts sop_out_asserts_inst (.CLK_I, .RESET_I, .REG_ADDR_I,
    .REG_WDATA_I, .REG_WR_I, .REG_RD_I, .REG_RDATA_O, .BCLK_O, .BCLK_OE_O, .LRCLK_O, .SDATA_O);

// file: sop_out_port.sv
// serial audio output port: control register, clock role, framing and data serialiser
`timescale 1ns/1ps
`include "sop_regs.svh"

module sop_out_port (
    input  wire logic          CLK_I,
    input  wire logic          RESET_I,
    input  wire logic [11:0]   REG_ADDR_I,
    input  wire logic [15:0]   REG_WDATA_I,
    input  wire logic          REG_WR_I,
    input  wire logic          REG_RD_I,
    output logic      [15:0]   REG_RDATA_O,
    input  wire logic          BCLK_I,
    output logic               BCLK_O,
    output logic               BCLK_OE_O,
    input  wire logic          LRCLK_I,
    output logic               LRCLK_O,
    output logic               LRCLK_OE_O,
    input  wire logic [191:0]  CH_DATA_I,
    output logic               SAMPLE_TAKE_O,
    output logic      [3:0]    SDATA_O
);

    logic [15:0]       serial_output_control_reg;
    logic              frame_clock_polarity;
    logic              bit_clock_edge_select;
    logic              clock_master;
    sop_pkg::sop_bdiv_t bit_clock_divider;
    sop_pkg::sop_fdiv_t frame_clock_divider;
    logic              frame_sync_shape;
    logic              tdm_enable;
    sop_pkg::sop_msb_t  msb_delay_code;
    sop_pkg::sop_wl_t   output_word_length;

    logic              bclk_m;
    logic              lrclk_m;
    logic              bclk_s_reg;
    logic              lrclk_s_reg;
    logic              bclk_now;
    logic              lrclk_now;
    logic              bclk_prev_reg;
    logic              lrclk_last_reg;
    logic              launch;
    logic              lr_edge;
    logic              frame_start;

    sop_pkg::sop_pos_t  bit_cnt_reg;
    sop_pkg::sop_pos_t  bit_cnt_next;
    sop_pkg::sop_pos_t  half_cnt_reg;
    sop_pkg::sop_pos_t  half_cnt_next;
    sop_pkg::sop_pos_t  frame_len_reg;
    sop_pkg::sop_pos_t  half_len;
    sop_pkg::sop_pos_t  word_pos;
    logic              right_ch;
    logic [2:0]        tdm_slot;
    sop_pkg::sop_len_t  msb_delay;
    sop_pkg::sop_len_t  word_bits;

    logic [23:0]       samp_reg [0:7];
    logic [23:0]       cur_word [0:7];
    logic [3:0]        sdata_next;
    logic [3:0]        sdata_reg;

    // ------------------------------------------------------------------
    // control register on the documented control port
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            serial_output_control_reg <= `SOP_CTRL_RESET;
        end else if (REG_WR_I && (REG_ADDR_I == `SOP_CTRL_ADDR)) begin
            serial_output_control_reg <= REG_WDATA_I & `SOP_CTRL_WMASK;
        end
    end

    // read data registered; unmapped addresses read zero
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            REG_RDATA_O <= 16'h0000;
        end else if (REG_RD_I) begin
            REG_RDATA_O <= (REG_ADDR_I == `SOP_CTRL_ADDR) ? serial_output_control_reg : 16'h0000;
        end
    end

    // field breakout
    assign frame_clock_polarity  = serial_output_control_reg[`SOP_POL_BIT];
    assign bit_clock_edge_select = serial_output_control_reg[`SOP_EDGE_BIT];
    assign clock_master          = serial_output_control_reg[`SOP_ROLE_BIT];
    assign bit_clock_divider     = serial_output_control_reg[`SOP_BDIV_MSB:`SOP_BDIV_LSB];
    assign frame_clock_divider   = serial_output_control_reg[`SOP_FDIV_MSB:`SOP_FDIV_LSB];
    assign frame_sync_shape      = serial_output_control_reg[`SOP_FST_BIT];
    assign tdm_enable            = serial_output_control_reg[`SOP_TDM_BIT];
    assign msb_delay_code        = serial_output_control_reg[`SOP_MSB_MSB:`SOP_MSB_LSB];
    assign output_word_length    = serial_output_control_reg[`SOP_WL_MSB:`SOP_WL_LSB];

    // ------------------------------------------------------------------
    // clock role: own divider in master mode, sampled pins in slave mode
    // ------------------------------------------------------------------
    sop_clkgen u_clkgen (
        .clk_i   (CLK_I),
        .rst_i   (RESET_I),
        .bdiv_i  (bit_clock_divider),
        .fdiv_i  (frame_clock_divider),
        .edge_i  (bit_clock_edge_select),
        .pol_i   (frame_clock_polarity),
        .fst_i   (frame_sync_shape),
        .bclk_o  (bclk_m),
        .lrclk_o (lrclk_m)
    );

    assign BCLK_O     = bclk_m;
    assign LRCLK_O    = lrclk_m;
    assign BCLK_OE_O  = clock_master;
    assign LRCLK_OE_O = clock_master;

    // slave clocks are synchronous inputs; one stage aligns them with master timing
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            bclk_s_reg  <= 1'b0;
            lrclk_s_reg <= 1'b0;
        end else begin
            bclk_s_reg  <= BCLK_I;
            lrclk_s_reg <= LRCLK_I;
        end
    end

    assign bclk_now  = clock_master ? bclk_m : bclk_s_reg;
    assign lrclk_now = clock_master ? lrclk_m : lrclk_s_reg;

    // ------------------------------------------------------------------
    // launch edge and frame detection
    // ------------------------------------------------------------------
    assign launch  = (bclk_now ^ bclk_prev_reg) & (bclk_now == bit_clock_edge_select);
    assign lr_edge = lrclk_now ^ lrclk_last_reg;
    // word clock: frame opens when the clock enters the left level
    assign frame_start = frame_sync_shape ? (lrclk_now & ~lrclk_last_reg)
                       : (lr_edge & (lrclk_now == frame_clock_polarity));

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            bclk_prev_reg  <= 1'b0;
            lrclk_last_reg <= 1'b0;
        end else begin
            bclk_prev_reg <= bclk_now;
            if (launch) begin
                lrclk_last_reg <= lrclk_now;
            end
        end
    end

    // position counters saturate so a stalled slave clock cannot wrap them
    always_comb begin
        bit_cnt_next  = frame_start ? 10'h000 : bit_cnt_reg + {9'h000, ~&bit_cnt_reg};
        half_cnt_next = lr_edge ? 10'h000 : half_cnt_reg + {9'h000, ~&half_cnt_reg};
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            bit_cnt_reg   <= 10'h3FF;
            half_cnt_reg  <= 10'h3FF;
            frame_len_reg <= 10'h040;
        end else if (launch) begin
            bit_cnt_reg  <= bit_cnt_next;
            half_cnt_reg <= half_cnt_next;
            if (frame_start) begin
                frame_len_reg <= bit_cnt_reg + 10'h001;   // pulse mode splits frame by this
            end
        end
    end

    // ------------------------------------------------------------------
    // slot selection, delay and word length decode
    // ------------------------------------------------------------------
    always_comb begin
        half_len = frame_len_reg >> 1;
        tdm_slot = bit_cnt_next[`SOP_TDM_SLOT_SHIFT+2:`SOP_TDM_SLOT_SHIFT];
        if (tdm_enable) begin
            right_ch = 1'b0;
            word_pos = {5'h00, bit_cnt_next[`SOP_TDM_SLOT_SHIFT-1:0]};
        end else if (frame_sync_shape) begin
            right_ch = (bit_cnt_next >= half_len);
            word_pos = right_ch ? bit_cnt_next - half_len : bit_cnt_next;
        end else begin
            right_ch = (lrclk_now != frame_clock_polarity);
            word_pos = half_cnt_next;
        end
        case (msb_delay_code)
            3'h0:    msb_delay = 5'h01;
            3'h1:    msb_delay = 5'h00;
            3'h2:    msb_delay = 5'h08;
            3'h3:    msb_delay = 5'h0C;
            3'h4:    msb_delay = 5'h10;
            default: msb_delay = 5'h01;
        endcase
        case (output_word_length)
            2'b01:   word_bits = 5'h14;
            2'b10:   word_bits = 5'h10;
            default: word_bits = 5'h18;
        endcase
    end

    // msb first; anything outside the word window is zero
    function automatic logic pick_bit(input logic [23:0] w,
                                      input logic [9:0]  p,
                                      input logic [4:0]  d,
                                      input logic [4:0]  n);
        logic [9:0] i;
        i = p - {5'h00, d};
        if ((p >= {5'h00, d}) && (i < {5'h00, n})) begin
            pick_bit = w[5'd23 - i[4:0]];
        end else begin
            pick_bit = 1'b0;
        end
    endfunction : pick_bit

    // ------------------------------------------------------------------
    // sample latch at frame start; new words are used from their first bit
    // ------------------------------------------------------------------
    genvar c;
    generate
        for (c = 0; c < `SOP_CHANNELS; c = c + 1) begin : g_chan
            assign cur_word[c] = (launch && frame_start) ? CH_DATA_I[c*24 +: 24] : samp_reg[c];
            always_ff @(posedge CLK_I or posedge RESET_I) begin
                if (RESET_I) begin
                    samp_reg[c] <= 24'h000000;
                end else if (launch && frame_start) begin
                    samp_reg[c] <= CH_DATA_I[c*24 +: 24];
                end
            end
        end
    endgenerate

    // line k carries channels 2k and 2k+1; tdm puts all eight on line zero
    always_comb begin
        sdata_next = 4'h0;
        if (tdm_enable) begin
            if (bit_cnt_next < `SOP_TDM_FRAME_BITS) begin
                sdata_next[0] = pick_bit(cur_word[tdm_slot], word_pos, msb_delay, word_bits);
            end
        end else begin
            for (int k = 0; k < 4; k++) begin
                sdata_next[k] = pick_bit(cur_word[{k[1:0], right_ch}], word_pos,
                                         msb_delay, word_bits);
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            sdata_reg     <= 4'h0;
            SAMPLE_TAKE_O <= 1'b0;
        end else begin
            SAMPLE_TAKE_O <= launch & frame_start;
            if (launch) begin
                sdata_reg <= sdata_next;
            end
        end
    end

    assign SDATA_O = sdata_reg;

endmodule : sop_out_port

// file: sop_pkg.sv
// field types shared by the serial output port modules
package sop_pkg;

    typedef logic [1:0] sop_bdiv_t;   // bit clock divider code
    typedef logic [1:0] sop_fdiv_t;   // frame clock divider code
    typedef logic [2:0] sop_msb_t;    // msb delay code
    typedef logic [1:0] sop_wl_t;     // output word length code
    typedef logic [9:0] sop_pos_t;    // bit position inside a frame
    typedef logic [4:0] sop_len_t;    // small bit counts (delay, length)

endpackage : sop_pkg

// file: sop_regs.svh
// register offset, field positions, reset value and fixed counts of the serial output port
`ifndef SOP_REGS_SVH
`define SOP_REGS_SVH

// ----------------------------------------------------------------------
// control register
// ----------------------------------------------------------------------
`define SOP_CTRL_ADDR       12'h81E
`define SOP_CTRL_RESET      16'h0000
`define SOP_CTRL_WMASK      16'h9FFF
`define SOP_POL_BIT         15
`define SOP_EDGE_BIT        12
`define SOP_ROLE_BIT        11
`define SOP_BDIV_MSB        10
`define SOP_BDIV_LSB        9
`define SOP_FDIV_MSB        8
`define SOP_FDIV_LSB        7
`define SOP_FST_BIT         6
`define SOP_TDM_BIT         5
`define SOP_MSB_MSB         4
`define SOP_MSB_LSB         2
`define SOP_WL_MSB          1
`define SOP_WL_LSB          0

// ----------------------------------------------------------------------
// stream layout
// ----------------------------------------------------------------------
`define SOP_SAMPLE_BITS     24
`define SOP_CHANNELS        8
`define SOP_TDM_SLOT_SHIFT  5
`define SOP_TDM_FRAME_BITS  10'd256

`endif

// file: sop_rx_model.sv
// far-side receiver: clock source in slave mode, gathers frames of the one serial line it is given
`timescale 1ns/1ps

module sop_rx_model (
    input  wire logic          clk_i,
    input  wire logic          gen_i,
    input  wire logic          edge_i,
    input  wire logic          pol_i,
    input  wire logic          fst_i,
    input  wire logic          bclk_i,
    input  wire logic          lrclk_i,
    input  wire logic          sdata_i,
    output logic               bclk_o,
    output logic               lrclk_o,
    output logic               done_o,
    output logic [255:0]       frame_o,
    output int                 nbits_o
);
    logic [1:0]   div = 2'd0;
    logic [5:0]   bit_n = 6'd0;
    logic         b_q = 1'b0;
    logic         l_q = 1'b0;
    logic [255:0] sh = '0;
    int           cnt = 0;
    initial begin
        bclk_o = 1'b0;
        lrclk_o = 1'b0;
        done_o = 1'b0;
        frame_o = '0;
        nbits_o = 0;
    end

    // clock source: 8-cycle bit clock, 64 bits a frame; stands still once released
    always @(posedge clk_i) if (gen_i) begin
        div <= div + 2'd1;
        if (div == 2'd3) begin
            bclk_o <= !bclk_o;
            if (!bclk_o == edge_i) begin
                bit_n <= bit_n + 6'd1;
                if (bit_n == 6'd63) lrclk_o <= pol_i;
                if (bit_n == 6'd31) lrclk_o <= !pol_i;
            end
        end
    end

    // capture on the edge opposite launch; frame starts at left half or pulse rise
    always @(posedge clk_i) begin
        b_q <= bclk_i;
        l_q <= lrclk_i;
        done_o <= 1'b0;
        if (lrclk_i != l_q && (fst_i ? lrclk_i : lrclk_i == pol_i)) begin
            done_o <= 1'b1;
            frame_o <= sh;
            nbits_o <= cnt;
            cnt = 0;
            sh = '0;
        end
        if (bclk_i != b_q && bclk_i != edge_i) begin
            sh = {sh[254:0], sdata_i};
            cnt = cnt + 1;
        end
    end
endmodule : sop_rx_model

// file: tb_sop_out_port.sv
// self-checking bench: register port, clock role and frame contents of the output port
`timescale 1ns/1ps

module tb_sop_out_port;
    logic         CLK_I = 1'b0;
    logic         RESET_I = 1'b1;
    logic [11:0]  REG_ADDR_I = 12'h000;
    logic [15:0]  REG_WDATA_I = 16'h0000;
    logic         REG_WR_I = 1'b0;
    logic         REG_RD_I = 1'b0;
    logic [191:0] CH_DATA_I = '0;
    logic [15:0]  REG_RDATA_O;
    logic         BCLK_O, BCLK_OE_O, LRCLK_O, LRCLK_OE_O, SAMPLE_TAKE_O;
    logic [3:0]   SDATA_O;
    logic         p_bclk, p_lrclk, done;
    logic [255:0] frame;
    int           nbits;
    logic [15:0]  cfg = 16'h0000;
    int           n_mismatch = 0;
    int           tests_run = 0;
    int           ln = 0;       // stereo line watched by the receiver model
    int           n_take = 0;   // sample take pulses seen so far
    int           dly[5] = '{1, 0, 8, 12, 16};
    int           wlen[3] = '{24, 20, 16};
    // no reserved divider, delay or length codes in the table
    logic [15:0]  cfgs[10] = '{16'h6800, 16'h8809, 16'h1806, 16'h084C, 16'h0810,
                               16'h0C20, 16'h0A80, 16'h0F00, 16'h0000, 16'h9000};
    wire          bclk_pin = BCLK_OE_O ? BCLK_O : p_bclk;
    wire          lrclk_pin = LRCLK_OE_O ? LRCLK_O : p_lrclk;

    always #5 CLK_I = !CLK_I;

    // count take pulses; non-blocking so a read on the same edge sees the old count
    always @(posedge CLK_I) if (SAMPLE_TAKE_O === 1'b1) n_take <= n_take + 1;

    sop_out_port sop_out_port_inst (.CLK_I, .RESET_I, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I,
        .REG_RD_I, .REG_RDATA_O, .BCLK_I(bclk_pin), .BCLK_O, .BCLK_OE_O, .LRCLK_I(lrclk_pin),
        .LRCLK_O, .LRCLK_OE_O, .CH_DATA_I, .SAMPLE_TAKE_O, .SDATA_O);
    sop_rx_model sop_rx_model_inst (.clk_i(CLK_I), .gen_i(!cfg[11]), .edge_i(cfg[12]),
        .pol_i(cfg[15]), .fst_i(cfg[6]), .bclk_i(bclk_pin), .lrclk_i(lrclk_pin),
        .sdata_i(SDATA_O[ln]), .bclk_o(p_bclk), .lrclk_o(p_lrclk), .done_o(done),
        .frame_o(frame), .nbits_o(nbits));

    // ------
    // tasks
    // ------
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude
    task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %0t register got %h want %h", $time, g, e);
        end
    endtask : cmp16
    task automatic cmp_frame(input logic [255:0] g, input logic [255:0] e,
                             input int gn, input int en);
        tests_run++;
        if (g !== e || gn != en) begin
            n_mismatch++;
            $display("ERROR %0t frame of %0d bits differs, want %0d bits", $time, gn, en);
        end
    endtask : cmp_frame
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge CLK_I);
        REG_ADDR_I <= a;
        REG_WDATA_I <= d;
        REG_WR_I <= 1'b1;
        @(posedge CLK_I);
        REG_WR_I <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [15:0] d);
        @(posedge CLK_I);
        REG_ADDR_I <= a;
        REG_RD_I <= 1'b1;
        @(posedge CLK_I);
        REG_RD_I <= 1'b0;
        @(posedge CLK_I);
        d = REG_RDATA_O;
    endtask : rd
    task automatic wait_done();
        int k;
        k = 0;
        @(posedge CLK_I);
        while (done !== 1'b1 && k < 4000) begin
            @(posedge CLK_I);
            k++;
        end
        if (k >= 4000) begin
            n_mismatch++;
            $display("ERROR %0t no frame seen", $time);
        end
    endtask : wait_done
    // reference frame: bit p of a slot is sample bit 23-(p-d) inside the word, else zero
    task automatic expect_frame(output logic [255:0] e, output int n);
        int sw, d, w, c, q;
        n = cfg[11] ? (1024 >> cfg[8:7]) / (16 >> cfg[10:9]) : 64;
        sw = cfg[5] ? 32 : n / 2;
        d = dly[cfg[4:2]];
        w = wlen[cfg[1:0]];
        e = '0;
        for (int p = 0; p < n; p++) begin
            c = p / sw + (cfg[5] ? 0 : 2 * ln);
            q = p % sw;
            e = {e[254:0], (q >= d && q < d + w && c < 8) ? CH_DATA_I[c*24 + 23 - (q - d)] : 1'b0};
        end
    endtask : expect_frame
    task automatic run_cfg(input logic [15:0] c);
        logic [15:0]  r;
        logic [255:0] e;
        int           n;
        int           t0;
        wr(12'h81E, c);
        cfg <= c & 16'h9FFF;
        // any of the four stereo lines may be watched; tdm lives on line zero only
        ln <= c[5] ? 0 : int'($urandom_range(3));
        for (int i = 0; i < 6; i++) CH_DATA_I[i*32 +: 32] <= $urandom();
        rd(12'h81E, r);
        cmp16(r, c & 16'h9FFF);
        cmp16({15'h0000, BCLK_OE_O & LRCLK_OE_O}, {15'h0000, c[11]});
        repeat (2) wait_done();
        t0 = n_take;
        wait_done();
        cmp16(16'(n_take - t0), 16'h0001);
        expect_frame(e, n);
        cmp_frame(frame, e, nbits, n);
    endtask : run_cfg

    // watchdog sized for ten configurations of three frames each
    initial begin
        repeat (80000) @(posedge CLK_I);
        n_mismatch++;
        conclude();
    end

    // main sequence
    initial begin
        logic [15:0] r;
        void'($urandom(32'h5e41));
        repeat (3) @(posedge CLK_I);
        RESET_I <= 1'b0;
        cmp16({15'h0000, BCLK_OE_O | LRCLK_OE_O}, 16'h0000);
        wr(12'h81F, 16'hFFFF);
        rd(12'h81F, r);
        cmp16(r, 16'h0000);
        rd(12'h81E, r);
        cmp16(r, 16'h0000);
        foreach (cfgs[i]) run_cfg(cfgs[i]);
        @(posedge CLK_I);
        RESET_I <= 1'b1;
        @(posedge CLK_I);
        RESET_I <= 1'b0;
        rd(12'h81E, r);
        cmp16(r | {15'h0000, BCLK_OE_O}, 16'h0000);
        conclude();
    end
endmodule : tb_sop_out_port
